// ==== include/rfo_pkg.sv ====
// Package with types and constants for the relay and fan output select block.
package rfo_pkg;

  // Relay function codes (one of seven starter conditions).
  typedef enum logic [2:0] {
    RFO_FN_STOPPED     = 3'h0,
    RFO_FN_NOT_STOPPED = 3'h1,
    RFO_FN_STARTING    = 3'h2,
    RFO_FN_RUNNING     = 3'h3,
    RFO_FN_READY       = 3'h4,
    RFO_FN_TRIP        = 3'h5,
    RFO_FN_ALARM       = 3'h6
  } rfo_relay_fn_t;

  // Fan management modes.
  typedef enum logic [1:0] {
    RFO_FAN_AUTO = 2'h0,
    RFO_FAN_ON   = 2'h1,
    RFO_FAN_OFF  = 2'h2,
    RFO_FAN_HAND = 2'h3
  } rfo_fan_mode_t;

  // Logic input assignment codes relevant to this block.
  typedef enum logic [1:0] {
    RFO_LI_OTHER = 2'h0,
    RFO_LI_FAN   = 2'h1
  } rfo_li_fn_t;

  // Starter condition as seen by the output logic.
  typedef struct packed {
    logic stopped;
    logic starting;
    logic bypassClosed;
    logic mainsPresent;
    logic tripActive;
    logic startLimitHit;
    logic alarmActive;
    logic fanAutoDemand;
  } rfo_status_t;

  // Settings as held in the block.
  typedef struct packed {
    rfo_relay_fn_t relayOneFn;
    rfo_relay_fn_t relayTwoFn;
    rfo_fan_mode_t fanMode;
  } rfo_cfg_t;

  localparam rfo_relay_fn_t RFO_RST_RELAY_ONE = RFO_FN_NOT_STOPPED;
  localparam rfo_relay_fn_t RFO_RST_RELAY_TWO = RFO_FN_TRIP;
  localparam rfo_fan_mode_t RFO_RST_FAN       = RFO_FAN_AUTO;

  // Overload alarm threshold in percent of thermal state.
  localparam logic [7:0] RFO_OVL_ALARM_PCT = 8'h6E;

endpackage

// ==== hw/rfo_relay_fan_select.sv ====
// Relay and fan output assignment logic of a motor soft starter.
`timescale 1ns/1ps
module rfo_relay_fan_select (
  input  wire logic                 clk_sys,         // 50 MHz system clock
  input  wire logic                 sys_rst,         // Sync reset, active high
  input  wire rfo_pkg::rfo_status_t starterStatus,   // Starter condition
  input  wire logic [7:0]           thermalPct,      // Thermal state, percent
  input  wire logic                 advancedMode,    // Advanced mode enabled
  input  wire logic                 cfgWrite,        // Setting write strobe
  input  wire logic [1:0]           cfgSelect,       // 0 relay1, 1 relay2, 2 fan
  input  wire logic [2:0]           cfgData,         // Written code
  input  wire rfo_pkg::rfo_li_fn_t  liTwoFn,         // logic_input_two function
  input  wire rfo_pkg::rfo_li_fn_t  liThreeFn,       // logic_input_three function
  input  wire logic                 logicInputTwo,   // logic_input_two pin
  input  wire logic                 logicInputThree, // logic_input_three pin
  output logic                      relayOneOutput,  // Relay one coil drive
  output logic                      relayTwoOutput,  // Relay two coil drive
  output logic                      fanOutput,       // Fan drive
  output logic                      cfgReject,       // Write refused, pulse
  output rfo_pkg::rfo_cfg_t         cfgReadback      // Settings, 0 if hidden
);

  rfo_pkg::rfo_cfg_t cfg;
  logic [1:0] liTwoSync;
  logic [1:0] liThreeSync;

  // Pins are asynchronous to clk_sys.
  always_ff @(posedge clk_sys) begin
    liTwoSync   <= {liTwoSync[0], logicInputTwo};
    liThreeSync <= {liThreeSync[0], logicInputThree};
  end

  wire selRelayOne = (cfgSelect == 2'h0);
  wire selRelayTwo = (cfgSelect == 2'h1);
  wire selFan      = (cfgSelect == 2'h2);
  wire validFn     = (cfgData <= 3'(rfo_pkg::RFO_FN_ALARM));
  wire isRelaySel  = selRelayOne | selRelayTwo;
  // Relay changes while running could drop a contactor unexpectedly.
  wire relayOk = cfgWrite & advancedMode & isRelaySel & validFn
                 & starterStatus.stopped;
  wire fanOk   = cfgWrite & advancedMode & selFan;
  wire next_cfgReject = cfgWrite & ~relayOk & ~fanOk;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg.relayOneFn <= rfo_pkg::RFO_RST_RELAY_ONE;
      cfg.relayTwoFn <= rfo_pkg::RFO_RST_RELAY_TWO;
      cfg.fanMode    <= rfo_pkg::RFO_RST_FAN;
      cfgReject      <= 1'b0;
    end else begin
      if (relayOk && selRelayOne) begin
        cfg.relayOneFn <= rfo_pkg::rfo_relay_fn_t'(cfgData);
      end
      if (relayOk && selRelayTwo) begin
        cfg.relayTwoFn <= rfo_pkg::rfo_relay_fn_t'(cfgData);
      end
      if (fanOk) begin
        cfg.fanMode <= rfo_pkg::rfo_fan_mode_t'(cfgData[1:0]);
      end
      cfgReject <= next_cfgReject;
    end
  end

  assign cfgReadback = advancedMode ? cfg : '0;

  // Status decode shared by both relays.
  wire overloadAlarm = thermalPct > rfo_pkg::RFO_OVL_ALARM_PCT;
  wire anyAlarm      = starterStatus.alarmActive | overloadAlarm;
  wire startingNow   = starterStatus.starting
                       & ~starterStatus.bypassClosed;
  wire readyNow      = starterStatus.mainsPresent & ~starterStatus.tripActive
                       & ~starterStatus.startLimitHit;

  // Indexed by function code; the unused eighth code leaves a relay off.
  wire [7:0] fnLevel = {
    1'b0,
    ~anyAlarm,
    ~starterStatus.tripActive,
    readyNow,
    starterStatus.bypassClosed,
    startingNow,
    ~starterStatus.stopped,
    starterStatus.stopped
  };

  wire next_relayOne = fnLevel[cfg.relayOneFn];
  wire next_relayTwo = fnLevel[cfg.relayTwoFn];

  // Manual fan follows whichever logic input is assigned fan control.
  wire liTwoFan     = (liTwoFn == rfo_pkg::RFO_LI_FAN);
  wire liThreeFan   = (liThreeFn == rfo_pkg::RFO_LI_FAN);
  wire fanHandLevel = (liTwoFan & liTwoSync[1])
                    | (liThreeFan & liThreeSync[1]);

  logic next_fan;
  always_comb begin
    unique case (cfg.fanMode)
      rfo_pkg::RFO_FAN_AUTO: next_fan = starterStatus.fanAutoDemand;
      rfo_pkg::RFO_FAN_ON:   next_fan = 1'b1;
      rfo_pkg::RFO_FAN_OFF:  next_fan = 1'b0;
      rfo_pkg::RFO_FAN_HAND: next_fan = fanHandLevel;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      relayOneOutput <= 1'b0;
      relayTwoOutput <= 1'b0;
      fanOutput      <= 1'b0;
    end else begin
      relayOneOutput <= next_relayOne;
      relayTwoOutput <= next_relayTwo;
      fanOutput      <= next_fan;
    end
  end

endmodule

// ==== dv/rfo_select_checker.sv ====
// Port assertions for the relay and fan output select block.
`timescale 1ns/1ps
module rfo_select_checker (
  input wire logic                 clk_sys, sys_rst, // Clock, reset
  input wire rfo_pkg::rfo_status_t starterStatus,    // Starter state
  input wire logic                 advancedMode,     // Settings shown
  input wire logic relayOneOutput, relayTwoOutput, fanOutput, // Drives
  input wire rfo_pkg::rfo_cfg_t    cfgReadback       // Settings view
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire rfo_pkg::rfo_status_t s = starterStatus;
  // The top bit marks a hidden view, so a zero readback never passes as code.
  wire logic [3:0] f1 = {!advancedMode, cfgReadback.relayOneFn};
  wire logic [3:0] f2 = {!advancedMode, cfgReadback.relayTwoFn};
  wire logic [2:0] fm = {!advancedMode, cfgReadback.fanMode};
  stop_fn_a: assert property (f1 == 4'h0 |=>
    relayOneOutput == $past(s.stopped)) else $error("stopped relay");
  busy_fn_a: assert property (f2 == 4'h1 |=>
    relayTwoOutput == !$past(s.stopped)) else $error("not stopped relay");
  start_fn_a: assert property (f1 == 4'h2 |=>
    relayOneOutput == $past(s.starting && !s.bypassClosed))
    else $error("start");
  run_fn_a: assert property (f2 == 4'h3 |=>
    relayTwoOutput == $past(s.bypassClosed)) else $error("running relay");
  trip_fn_a: assert property (f2 == 4'h5 |=>
    relayTwoOutput == !$past(s.tripActive)) else $error("trip relay");
  fan_auto_a: assert property (fm == 3'h0 |=>
    fanOutput == $past(s.fanAutoDemand)) else $error("fan auto");
  fan_force_a: assert property (fm == 3'h1 || fm == 3'h2 |=>
    fanOutput == $past(fm == 3'h1)) else $error("fan forced");
  hide_cfg_a: assert property (!advancedMode |->
    cfgReadback == 8'h00) else $error("settings not hidden");
endmodule
bind rfo_relay_fan_select rfo_select_checker chk (.clk_sys, .sys_rst,
  .starterStatus, .advancedMode, .relayOneOutput, .relayTwoOutput,
  .fanOutput, .cfgReadback);

// ==== dv/rfo_contactor_model.sv ====
// Wiring model: the trip relay holds the line contactor that feeds mains.
`timescale 1ns/1ps
module rfo_contactor_model (
  input  wire logic relayOneOutput, relayTwoOutput, // Relay contacts
  input  wire logic tripOnOne,                      // Trip sits on relay one
  output logic      lineOn                          // Mains reaches starter
);
  assign lineOn = tripOnOne ? relayOneOutput : relayTwoOutput;
endmodule

// ==== dv/rfo_relay_fan_select_test.sv ====
// Random self-checking bench for the relay and fan output select block.
`timescale 1ns/1ps
module rfo_relay_fan_select_test;
  logic clk_sys = 0, sys_rst = 1, advancedMode = 1, cfgWrite = 0, adv = 1;
  logic logicInputTwo = 0, logicInputThree = 0, lineOn, relayOneOutput;
  logic relayTwoOutput, fanOutput, cfgReject;
  logic [1:0] cfgSelect = 0, fm = 0;
  logic [2:0] cfgData = 0, h2 = 0, h3 = 0, r1 = 1, r2 = 5;
  logic [3:0] e = 0;
  logic [7:0] thermalPct = 0;
  logic [31:0] rnd;
  rfo_pkg::rfo_status_t starterStatus = 0;
  rfo_pkg::rfo_li_fn_t liTwoFn = rfo_pkg::RFO_LI_FAN;
  rfo_pkg::rfo_li_fn_t liThreeFn = rfo_pkg::RFO_LI_FAN;
  rfo_pkg::rfo_cfg_t cfgReadback;
  int seed = 32'hDD59E280, tick = 0, errors = 0, check_count = 0;
  wire rfo_pkg::rfo_status_t s = starterStatus;
  wire logic [6:0] fnV = {!(s.alarmActive || thermalPct > 8'h6E),
    !s.tripActive, s.mainsPresent && !s.tripActive && !s.startLimitHit,
    s.bypassClosed, s.starting && !s.bypassClosed, !s.stopped, s.stopped};
  wire logic [3:0] fanV = {liTwoFn[0] && h2[2] || liThreeFn[0] && h3[2],
    2'b01, s.fanAutoDemand};
  initial forever #10 clk_sys = !clk_sys;
  rfo_relay_fan_select dut (.clk_sys, .sys_rst, .starterStatus, .thermalPct,
    .advancedMode, .cfgWrite, .cfgSelect, .cfgData, .liTwoFn, .liThreeFn,
    .logicInputTwo, .logicInputThree, .relayOneOutput, .relayTwoOutput,
    .fanOutput, .cfgReject, .cfgReadback);
  rfo_contactor_model wiring (.relayOneOutput, .relayTwoOutput,
    .tripOnOne(r1 == 3'h5), .lineOn);
  task automatic chk(string n, logic [7:0] x, logic [7:0] y);
    check_count++;
    if (x !== y) errors++;
    if (x !== y) $display("Error %s expected %h seen %h", n, x, y);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (++tick == 4000) errors++;
    if (tick == 4000) print_verdict();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    sys_rst = 0;
    repeat (3000) begin
      chk("outputs", e, {relayOneOutput, relayTwoOutput, fanOutput, cfgReject});
      chk("settings", adv ? {r1, r2, fm} : 8'h00, cfgReadback);
      rnd = $random(seed);
      starterStatus = rnd[7:0];
      starterStatus.mainsPresent = lineOn;
      thermalPct = 8'h6B + 8'(rnd[10:8]);
      advancedMode = (rnd[13:11] != 3'h0);
      {cfgWrite, cfgSelect, cfgData} = rnd[19:14];
      {logicInputTwo, logicInputThree} = rnd[21:20];
      // Assignments change too, so manual fan must pick the right input.
      liTwoFn = rfo_pkg::rfo_li_fn_t'({1'b0, rnd[22]});
      liThreeFn = rfo_pkg::rfo_li_fn_t'({1'b0, rnd[23]});
      // Never strip the trip function from both relays, the wiring needs it.
      if (cfgSelect < 2 && (cfgSelect[0] ? r1 : r2) != 5) cfgData = 3'h5;
      h2 = {h2[1:0], logicInputTwo};
      h3 = {h3[1:0], logicInputThree};
      #1;
      adv = advancedMode;
      e = {fnV[r1], fnV[r2], fanV[fm], 1'b0};
      e[0] = cfgWrite && (cfgSelect[1] ? !adv || cfgSelect[0]
        : !adv || !s.stopped || cfgData == 3'h7);
      if (cfgWrite && !e[0] && cfgSelect == 0) r1 = cfgData;
      if (cfgWrite && !e[0] && cfgSelect == 1) r2 = cfgData;
      if (cfgWrite && !e[0] && cfgSelect == 2) fm = cfgData[1:0];
      @(negedge clk_sys);
    end
    print_verdict();
  end
endmodule
